// ==== iopc_regs.svh ====
// Constants for the port pin control block: write selects, pin-form
// field positions, reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef IOPC_REGS_SVH
`define IOPC_REGS_SVH

// ----------------------------------------
// Port-form write selects
// ----------------------------------------
`define IOPC_R_DR 4'h0
`define IOPC_R_DM0 4'h1
`define IOPC_R_DM1 4'h2
`define IOPC_R_DM2 4'h3
`define IOPC_R_BYP 4'h4
`define IOPC_R_SLW 4'h5
`define IOPC_R_BIE 4'h6
`define IOPC_R_INPD 4'h7
`define IOPC_R_RISE 4'h8
`define IOPC_R_FALL 4'h9
`define IOPC_R_CTL 4'hA
`define IOPC_R_OESEL 4'hB

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IOPC_PF_DR 0
`define IOPC_PF_DM 1
`define IOPC_PF_BYP 4
`define IOPC_PF_SLW 5
`define IOPC_PF_BIE 6
`define IOPC_PF_INPD 7
`define IOPC_CTL_LVTTL 0
`define IOPC_OES_PIN 0
`define IOPC_OES_SEL 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IOPC_RST_PORT 8'h00
`define IOPC_RST_OESEL 4'h0

`endif

// ==== iopc_pkg.sv ====
// Types shared by the port pin control block.
// Assumes nothing of its surroundings.
package iopc_pkg;
  // Drive mode codes 0..7 in declaration order
  typedef enum logic [2:0] {
    IOPC_DM_HIZ_ANA, IOPC_DM_HIZ_DIG, IOPC_DM_RES_UP, IOPC_DM_RES_DN,
    IOPC_DM_OD_LO, IOPC_DM_OD_HI, IOPC_DM_STRONG, IOPC_DM_RES_UPDN
  } iopc_dm_type;
endpackage : iopc_pkg

// ==== iopc_pin_if.sv ====
// Per-pin bundle between the port control and the drive decoder.
// Assumes one instance per pin, all on the port clock.
`timescale 1ns/1ps
`default_nettype none
interface iopc_pin_if;
  import iopc_pkg::*;
  iopc_dm_type dm;
  logic dat, bie, oe_hw, sio_reg, inp_dis, slw;
  logic oe, out, pu, pd, ibuf, slow;
  modport cfg(output dm, dat, bie, oe_hw, sio_reg, inp_dis, slw,
              input oe, out, pu, pd, ibuf, slow);
  modport drv(input dm, dat, bie, oe_hw, sio_reg, inp_dis, slw,
              output oe, out, pu, pd, ibuf, slow);
endinterface : iopc_pin_if
`default_nettype wire

// ==== iopc_pin_drive.sv ====
// Drive decoder for one pin: mode, data and hardware enable to pad controls.
// Assumes the caller registers the results before they reach the pad.
`timescale 1ns/1ps
`default_nettype none
module iopc_pin_drive
  import iopc_pkg::*;
(
  iopc_pin_if.drv pin
);
  logic drv_on;
  logic strong_ok;
  // Bidirectional use parks the pin in digital high-Z while enable is low
  assign drv_on = !pin.bie || pin.oe_hw;
  assign strong_ok = (pin.dm == IOPC_DM_OD_LO) || (pin.dm == IOPC_DM_OD_HI) ||
                     (pin.dm == IOPC_DM_STRONG);

  always_comb begin
    pin.oe = 1'b0;
    pin.out = pin.dat;
    pin.pu = 1'b0;
    pin.pd = 1'b0;
    pin.ibuf = !pin.inp_dis;
    case (pin.dm)
      IOPC_DM_HIZ_ANA: pin.ibuf = 1'b0;
      IOPC_DM_HIZ_DIG: pin.oe = 1'b0;
      IOPC_DM_RES_UP: begin
        pin.oe = drv_on && !pin.dat;
        pin.pu = drv_on && pin.dat;
      end
      IOPC_DM_RES_DN: begin
        pin.oe = drv_on && pin.dat;
        pin.pd = drv_on && !pin.dat;
      end
      IOPC_DM_OD_LO: pin.oe = drv_on && !pin.dat;
      IOPC_DM_OD_HI: pin.oe = drv_on && pin.dat;
      IOPC_DM_STRONG: pin.oe = drv_on;
      IOPC_DM_RES_UPDN: begin
        pin.pu = drv_on && pin.dat;
        pin.pd = drv_on && !pin.dat;
      end
      default: pin.oe = 1'b0;
    endcase
    // Regulated special pins have no resistive legs; those halves float
    if (pin.sio_reg) begin
      pin.pu = 1'b0;
      pin.pd = 1'b0;
    end
    pin.slow = pin.slw && strong_ok && pin.oe;
  end
endmodule : iopc_pin_drive
`default_nettype wire

// ==== iopc_edge_det.sv ====
// Pin input synchroniser and edge detector for one pin.
// Assumes an asynchronous pad input and a free-running port clock.
`timescale 1ns/1ps
`default_nettype none
module iopc_edge_det (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic ibuf_en,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic level,
  output logic evt
);
  logic s1_q, s2_q, s3_q;
  // Two flops before any logic looks at the pad
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign level = s2_q;
  // Edges only: a held level never repeats the event
  assign evt = ibuf_en && ((rise_en && s2_q && !s3_q) ||
                           (fall_en && !s2_q && s3_q));
endmodule : iopc_edge_det
`default_nettype wire

// ==== iopc_port.sv ====
// Pin control for one I/O port: configuration state, drive, edge interrupts.
// Assumes configuration writes and bypass data come from the port clock;
// pad inputs are asynchronous and are synchronised inside.
`timescale 1ns/1ps
`default_nettype none
`include "iopc_regs.svh"

module iopc_port
  import iopc_pkg::*;
#(
  parameter int NPIN = 8,
  parameter int AUX_W = 16
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PORT_WR,
  input wire logic [3:0] PORT_ADDR,
  input wire logic [7:0] PORT_WDATA,
  input wire logic PIN_WR,
  input wire logic [$clog2(NPIN)-1:0] PIN_IDX,
  input wire logic [7:0] PIN_WDATA,
  input wire logic STATUS_RD,
  input wire logic [2:0] NV_RST_DM,
  input wire logic [NPIN-1:0] BYP_DATA,
  input wire logic [AUX_W-1:0] AUX_OE,
  input wire logic [NPIN-1:0] SIO_REGULATED,
  input wire logic [NPIN-1:0] PIN_IN,
  output logic [NPIN-1:0] PIN_OUT,
  output logic [NPIN-1:0] PIN_OE,
  output logic [NPIN-1:0] PIN_PU_EN,
  output logic [NPIN-1:0] PIN_PD_EN,
  output logic [NPIN-1:0] PIN_IBUF_EN,
  output logic [NPIN-1:0] PIN_SLOW,
  output logic LVTTL_SEL,
  output logic [NPIN-1:0] PIN_STATE,
  output logic [NPIN-1:0] IRQ_STATUS,
  output logic IRQ
);
  localparam int SELW = $clog2(AUX_W);

  // ----------------------------------------
  // Port-form registers
  // ----------------------------------------
  logic [NPIN-1:0] dr_q, dm0_q, dm1_q, dm2_q, byp_q, slw_q;
  logic [NPIN-1:0] bie_q, inpd_q, rise_q, fall_q;
  logic [NPIN-1:0] dr_d, dm0_d, dm1_d, dm2_d, byp_d, slw_d;
  logic [NPIN-1:0] bie_d, inpd_d, rise_d, fall_d;
  logic lvttl_q;
  logic rst_load_q;
  logic [SELW-1:0] oe_sel_q [NPIN];

  logic wr_dr, wr_dm0, wr_dm1, wr_dm2, wr_byp, wr_slw;
  logic wr_bie, wr_inpd, wr_rise, wr_fall, wr_ctl, wr_oes;
  logic [NPIN-1:0] pin_sel;
  logic [$clog2(NPIN)-1:0] oes_pin;

  assign wr_dr = PORT_WR && (PORT_ADDR == `IOPC_R_DR);
  assign wr_dm0 = PORT_WR && (PORT_ADDR == `IOPC_R_DM0);
  assign wr_dm1 = PORT_WR && (PORT_ADDR == `IOPC_R_DM1);
  assign wr_dm2 = PORT_WR && (PORT_ADDR == `IOPC_R_DM2);
  assign wr_byp = PORT_WR && (PORT_ADDR == `IOPC_R_BYP);
  assign wr_slw = PORT_WR && (PORT_ADDR == `IOPC_R_SLW);
  assign wr_bie = PORT_WR && (PORT_ADDR == `IOPC_R_BIE);
  assign wr_inpd = PORT_WR && (PORT_ADDR == `IOPC_R_INPD);
  assign wr_rise = PORT_WR && (PORT_ADDR == `IOPC_R_RISE);
  assign wr_fall = PORT_WR && (PORT_ADDR == `IOPC_R_FALL);
  assign wr_ctl = PORT_WR && (PORT_ADDR == `IOPC_R_CTL);
  assign wr_oes = PORT_WR && (PORT_ADDR == `IOPC_R_OESEL);
  assign pin_sel = PIN_WR ? (NPIN)'(1) << PIN_IDX : '0;
  assign oes_pin = PORT_WDATA[`IOPC_OES_PIN +: $clog2(NPIN)];

  // Port write wins over a pin write in the same cycle
  function automatic logic [NPIN-1:0] upd(input logic [NPIN-1:0] q,
                                          input logic pw,
                                          input logic pv);
    logic [NPIN-1:0] r;
    r = (q & ~pin_sel) | (pin_sel & {NPIN{pv}});
    if (pw) begin
      r = PORT_WDATA[NPIN-1:0];
    end
    return r;
  endfunction : upd

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  assign dr_d = upd(dr_q, wr_dr, PIN_WDATA[`IOPC_PF_DR]);
  assign byp_d = upd(byp_q, wr_byp, PIN_WDATA[`IOPC_PF_BYP]);
  assign slw_d = upd(slw_q, wr_slw, PIN_WDATA[`IOPC_PF_SLW]);
  assign bie_d = upd(bie_q, wr_bie, PIN_WDATA[`IOPC_PF_BIE]);
  assign inpd_d = upd(inpd_q, wr_inpd, PIN_WDATA[`IOPC_PF_INPD]);
  // Edge selects are not in the pin form
  assign rise_d = wr_rise ? PORT_WDATA[NPIN-1:0] : rise_q;
  assign fall_d = wr_fall ? PORT_WDATA[NPIN-1:0] : fall_q;
  // Stored reset modes land once, the cycle after release
  assign dm0_d = rst_load_q ? {NPIN{NV_RST_DM[0]}} :
                 upd(dm0_q, wr_dm0, PIN_WDATA[`IOPC_PF_DM]);
  assign dm1_d = rst_load_q ? {NPIN{NV_RST_DM[1]}} :
                 upd(dm1_q, wr_dm1, PIN_WDATA[`IOPC_PF_DM + 1]);
  assign dm2_d = rst_load_q ? {NPIN{NV_RST_DM[2]}} :
                 upd(dm2_q, wr_dm2, PIN_WDATA[`IOPC_PF_DM + 2]);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      dr_q <= `IOPC_RST_PORT;
      dm0_q <= `IOPC_RST_PORT;
      dm1_q <= `IOPC_RST_PORT;
      dm2_q <= `IOPC_RST_PORT;
      byp_q <= `IOPC_RST_PORT;
      slw_q <= `IOPC_RST_PORT;
      bie_q <= `IOPC_RST_PORT;
      inpd_q <= `IOPC_RST_PORT;
      rise_q <= `IOPC_RST_PORT;
      fall_q <= `IOPC_RST_PORT;
      lvttl_q <= 1'b0;
      rst_load_q <= 1'b1;
    end else begin
      dr_q <= dr_d;
      dm0_q <= dm0_d;
      dm1_q <= dm1_d;
      dm2_q <= dm2_d;
      byp_q <= byp_d;
      slw_q <= slw_d;
      bie_q <= bie_d;
      inpd_q <= inpd_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      if (wr_ctl) begin
        lvttl_q <= PORT_WDATA[`IOPC_CTL_LVTTL];
      end
      rst_load_q <= 1'b0;
    end
  end

  // Enable routing: each pin picks one of the auxiliary enables
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < NPIN; i++) begin
      if (RESET) begin
        oe_sel_q[i] <= SELW'(`IOPC_RST_OESEL);
      end else if (wr_oes && (oes_pin == i)) begin
        oe_sel_q[i] <= PORT_WDATA[`IOPC_OES_SEL +: SELW];
      end
    end
  end

  // ----------------------------------------
  // Per-pin drive and input
  // ----------------------------------------
  logic [NPIN-1:0] drv_oe, drv_out, drv_pu, drv_pd, drv_ibuf, drv_slow;
  logic [NPIN-1:0] lvl, evt;
  logic [NPIN-1:0] mode0_m, mode1_m, strong_m, resist_m, src;
  // Masks that let the checks pick out one drive case each
  logic [NPIN-1:0] resup_m, odlo_m, hw_off_m;

  for (genvar k = 0; k < NPIN; k++) begin : g_pin
    iopc_pin_if pif ();
    assign src[k] = byp_q[k] ? BYP_DATA[k] : dr_q[k];
    assign pif.dm = iopc_dm_type'({dm2_q[k], dm1_q[k], dm0_q[k]});
    assign pif.dat = src[k];
    assign pif.bie = bie_q[k];
    assign pif.oe_hw = AUX_OE[oe_sel_q[k]];
    assign pif.sio_reg = SIO_REGULATED[k];
    assign pif.inp_dis = inpd_q[k];
    assign pif.slw = slw_q[k];
    assign drv_oe[k] = pif.oe;
    assign drv_out[k] = pif.out;
    assign drv_pu[k] = pif.pu;
    assign drv_pd[k] = pif.pd;
    assign drv_ibuf[k] = pif.ibuf;
    assign drv_slow[k] = pif.slow;
    assign mode0_m[k] = (pif.dm == IOPC_DM_HIZ_ANA);
    assign mode1_m[k] = (pif.dm == IOPC_DM_HIZ_DIG);
    assign strong_m[k] = (pif.dm == IOPC_DM_STRONG) && !bie_q[k];
    assign resist_m[k] = (pif.dm == IOPC_DM_RES_UPDN);
    assign resup_m[k] = (pif.dm == IOPC_DM_RES_UP) && !bie_q[k] && !SIO_REGULATED[k];
    assign odlo_m[k] = (pif.dm == IOPC_DM_OD_LO) && !bie_q[k];
    assign hw_off_m[k] = bie_q[k] && !AUX_OE[oe_sel_q[k]];

    iopc_pin_drive u_drive (
      .pin(pif)
    );

    // Runs on the always-on port clock so sleep does not stop it
    iopc_edge_det u_edge (
      .clk(REF_CLK),
      .rst(RESET),
      .pin_in(PIN_IN[k]),
      .ibuf_en(PIN_IBUF_EN[k]),
      .rise_en(rise_q[k]),
      .fall_en(fall_q[k]),
      .level(lvl[k]),
      .evt(evt[k])
    );
  end

  // ----------------------------------------
  // Pad outputs, pin state
  // ----------------------------------------
  // Registered so the pad sees no decode glitches; costs one cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PIN_OUT <= '0;
      PIN_OE <= '0;
      PIN_PU_EN <= '0;
      PIN_PD_EN <= '0;
      PIN_IBUF_EN <= '0;
      PIN_SLOW <= '0;
      LVTTL_SEL <= 1'b0;
      PIN_STATE <= '0;
    end else begin
      PIN_OUT <= drv_out;
      PIN_OE <= drv_oe;
      PIN_PU_EN <= drv_pu;
      PIN_PD_EN <= drv_pd;
      PIN_IBUF_EN <= drv_ibuf;
      PIN_SLOW <= drv_slow;
      LVTTL_SEL <= lvttl_q;
      PIN_STATE <= lvl & PIN_IBUF_EN;
    end
  end

  // ----------------------------------------
  // Port interrupt unit
  // ----------------------------------------
  logic [NPIN-1:0] stat_d;
  // A new edge in the read cycle survives the clear
  assign stat_d = (IRQ_STATUS & ~{NPIN{STATUS_RD}}) | evt;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      IRQ_STATUS <= '0;
      IRQ <= 1'b0;
    end else begin
      IRQ_STATUS <= stat_d;
      IRQ <= |stat_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  chk_reset_hiz: assert property (
    $past(RESET) |-> (PIN_OE == '0) && (PIN_IBUF_EN == '0))
    else $error("pins not high-Z analog after reset");
  chk_nv_reload: assert property (
    rst_load_q |=> (dm2_q[0] == $past(NV_RST_DM[2])) &&
                   (dm0_q == {NPIN{$past(NV_RST_DM[0])}}))
    else $error("stored reset mode not loaded");
  chk_mode0_nobuf: assert property (
    ($past(mode0_m) & PIN_IBUF_EN) == '0)
    else $error("analog high-Z pin has input buffer on");
  chk_mode1_nodrive: assert property (
    ($past(mode1_m) & (PIN_OE | PIN_PU_EN | PIN_PD_EN)) == '0)
    else $error("digital high-Z pin drives");
  chk_strong_drive: assert property (
    (PIN_OE & $past(strong_m)) == $past(strong_m))
    else $error("strong pin not driving");
  chk_resist_noslew: assert property (
    ($past(resist_m) & PIN_SLOW) == '0)
    else $error("slew set on resistive pin");
  chk_inbuf_disable: assert property (
    ($past(inpd_q) & PIN_IBUF_EN) == '0)
    else $error("disabled input buffer is on");
  chk_pin_form: assert property (
    PIN_WR && !PORT_WR |=> dr_q[$past(PIN_IDX)] == $past(PIN_WDATA[0]))
    else $error("pin-form write lost");
  chk_edge_status: assert property (
    (evt != '0) |=> ((IRQ_STATUS & $past(evt)) == $past(evt)) && IRQ)
    else $error("edge did not set status");
  chk_read_clear: assert property (
    STATUS_RD && (evt == '0) |=> (IRQ_STATUS == '0) && !IRQ)
    else $error("status read did not clear");
  chk_irq_level: assert property (
    IRQ == (|IRQ_STATUS))
    else $error("request does not match status");
  chk_bypass_src: assert property (
    PIN_OUT == $past(src))
    else $error("pad data not from data bit or bypass");
  chk_res_up: assert property (
    ((PIN_PU_EN & $past(resup_m)) == $past(resup_m & src)) &&
    ((PIN_OE & $past(resup_m)) == $past(resup_m & ~src)))
    else $error("resistive pull-up mode drives the wrong leg");
  chk_od_low: assert property (
    (PIN_OE & $past(odlo_m)) == $past(odlo_m & ~src))
    else $error("open-drain low pin drives for data one");
  chk_sio_nopull: assert property (
    ($past(SIO_REGULATED) & (PIN_PU_EN | PIN_PD_EN)) == '0)
    else $error("regulated special pin has a pull leg on");
  chk_hw_release: assert property (
    ($past(hw_off_m) & (PIN_OE | PIN_PU_EN | PIN_PD_EN)) == '0)
    else $error("bidirectional pin drives with its enable low");
  chk_slow_drive: assert property (
    (PIN_SLOW & ~PIN_OE) == '0)
    else $error("slow slew on a pin that is not driving");
  chk_edge_enabled: assert property (
    ((IRQ_STATUS & ~$past(IRQ_STATUS)) & ~$past(rise_q | fall_q)) == '0)
    else $error("status set on a pin with no edge enabled");
  chk_lvttl_sel: assert property (
    wr_ctl |-> ##2 (LVTTL_SEL == $past(PORT_WDATA[`IOPC_CTL_LVTTL], 2)))
    else $error("threshold select not taken");
  chk_state_sync: assert property (
    PIN_STATE == ($past(PIN_IN, 3) & $past(PIN_IBUF_EN)))
    else $error("pin state not the synchronised pad level");
  chk_irq_hold: assert property (
    IRQ && !STATUS_RD |=> IRQ)
    else $error("request dropped without a status read");

  cov_edge_irq: cover property (evt != '0 ##1 IRQ ##[1:20] STATUS_RD);
  cov_pin_write: cover property (PIN_WR ##1 PORT_WR);
  cov_bidir: cover property ((PIN_OE & bie_q) != '0 ##[1:20] (PIN_OE & bie_q) == '0);
  cov_set_clear: cover property (STATUS_RD && evt != '0);
  cov_nv_mode: cover property (rst_load_q ##2 (PIN_PD_EN != '0));
endmodule : iopc_port
`default_nettype wire

// ==== iopc_pad_model.sv ====
// Pad and external circuitry model for one eight-pin port.
// Assumes pad controls from the port block and an optional external driver
// from the bench; a strong device driver wins over the external one.
`timescale 1ns/1ps
`default_nettype none
module iopc_pad_model (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pu,
  input wire logic [7:0] pd,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin
);
  logic [7:0] last_q = 8'h00;
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // A floating pad shows the inverse of its last level, so a stale value never
  // passes for a driven one
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (oe[k]) pin[k] = out[k];
      else if (ext_en[k]) pin[k] = ext_val[k];
      else if (pu[k]) pin[k] = 1'b1;
      else if (pd[k]) pin[k] = 1'b0;
      else pin[k] = ~last_q[k];
    end
  end
  // Per pin: only a driven pad refreshes its remembered level
  always @(posedge clk) begin
    for (int k = 0; k < 8; k++) begin
      if (oe[k] || ext_en[k] || pu[k] || pd[k]) begin
        last_q[k] <= pin[k];
      end
    end
  end
endmodule : iopc_pad_model
`default_nettype wire

// ==== iopc_port_tb.sv ====
// Self-checking bench for the port pin control block.
// Assumes the pad model closes the loop from pad controls to pad inputs.
`timescale 1ns/1ps
`default_nettype none
`include "iopc_regs.svh"
module iopc_port_tb;
  import iopc_pkg::*;
  logic REF_CLK, RESET, PORT_WR, PIN_WR, STATUS_RD, LVTTL_SEL, IRQ;
  logic [3:0] PORT_ADDR;
  logic [7:0] PORT_WDATA, PIN_WDATA, BYP_DATA, SIO_REGULATED, PIN_IN, PIN_OUT, PIN_OE;
  logic [7:0] PIN_PU_EN, PIN_PD_EN, PIN_IBUF_EN, PIN_SLOW, PIN_STATE, IRQ_STATUS;
  logic [7:0] ext_en, ext_val;
  logic [2:0] PIN_IDX, NV_RST_DM;
  logic [15:0] AUX_OE;
  int err_count = 0;
  int checks_done = 0;

  iopc_port i_dut (.REF_CLK(REF_CLK), .RESET(RESET), .PORT_WR(PORT_WR),
    .PORT_ADDR(PORT_ADDR), .PORT_WDATA(PORT_WDATA), .PIN_WR(PIN_WR), .PIN_IDX(PIN_IDX),
    .PIN_WDATA(PIN_WDATA), .STATUS_RD(STATUS_RD), .NV_RST_DM(NV_RST_DM),
    .BYP_DATA(BYP_DATA), .AUX_OE(AUX_OE), .SIO_REGULATED(SIO_REGULATED),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PU_EN(PIN_PU_EN),
    .PIN_PD_EN(PIN_PD_EN), .PIN_IBUF_EN(PIN_IBUF_EN), .PIN_SLOW(PIN_SLOW),
    .LVTTL_SEL(LVTTL_SEL), .PIN_STATE(PIN_STATE), .IRQ_STATUS(IRQ_STATUS), .IRQ(IRQ));
  iopc_pad_model i_pad (.clk(REF_CLK), .out(PIN_OUT), .oe(PIN_OE), .pu(PIN_PU_EN),
    .pd(PIN_PD_EN), .ext_en(ext_en), .ext_val(ext_val), .pin(PIN_IN));

  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Leaves the strobe high so consecutive calls make back-to-back writes
  task automatic port_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    PORT_WR <= 1'b1;
    PORT_ADDR <= a;
    PORT_WDATA <= d;
  endtask : port_wr
  task automatic settle();
    @(posedge REF_CLK);
    PORT_WR <= 1'b0;
    PIN_WR <= 1'b0;
    STATUS_RD <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask : settle
  task automatic set_mode(input logic [2:0] m, input logic [7:0] d);
    port_wr(`IOPC_R_DM0, {8{m[0]}});
    port_wr(`IOPC_R_DM1, {8{m[1]}});
    port_wr(`IOPC_R_DM2, {8{m[2]}});
    port_wr(`IOPC_R_DR, d);
    settle();
  endtask : set_mode
  task automatic final_report();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (6) @(posedge REF_CLK);
    RESET <= 1'b0;
    #1;
    check({PIN_OE, PIN_PU_EN}, 16'h0000);
    check({PIN_PD_EN, PIN_IBUF_EN}, 16'h0000);
    @(posedge REF_CLK);
    #1;
    check({PIN_OE, PIN_IBUF_EN}, 16'h0000);
    @(posedge REF_CLK);
    #1;
    check({PIN_PD_EN, PIN_PU_EN}, 16'hFF00);
    check(PIN_IBUF_EN, 16'h00FF);
    $display("test reset done");
  endtask : t_reset
  // Every code with both data values; slow slew requested on all pins
  task automatic t_modes();
    logic [4:0] e;
    logic d;
    // Pins here toggle every seven port clocks (140 ns), well above 1 MHz; slow slew is requested anyway
    port_wr(`IOPC_R_SLW, 8'hFF);
    for (int m = 0; m < 8; m++) begin
      for (int b = 0; b < 2; b++) begin
        d = b[0];
        set_mode(m[2:0], {8{d}});
        case (m)
          0: e = 5'b00000;
          1: e = 5'b00001;
          2: e = d ? 5'b00101 : 5'b10001;
          3: e = d ? 5'b11001 : 5'b00011;
          4: e = d ? 5'b00001 : 5'b10001;
          5: e = d ? 5'b11001 : 5'b00001;
          6: e = {1'b1, d, 3'b001};
          default: e = d ? 5'b00101 : 5'b00011;
        endcase
        check({PIN_OE, PIN_OUT & PIN_OE}, {{8{e[4]}}, {8{e[3]}}});
        check({PIN_PU_EN, PIN_PD_EN}, {{8{e[2]}}, {8{e[1]}}});
        check(PIN_IBUF_EN, {8{e[0]}});
        check(PIN_SLOW, {8{e[4] && m >= 4 && m <= 6}});
      end
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_bypass_sio();
    @(posedge REF_CLK);
    BYP_DATA <= 8'h05;
    port_wr(`IOPC_R_BYP, 8'h0F);
    set_mode(3'h6, 8'hFF);
    check(PIN_OUT, 16'h00F5);
    @(posedge REF_CLK);
    SIO_REGULATED <= 8'h0F;
    port_wr(`IOPC_R_BYP, 8'h00);
    set_mode(3'h7, 8'hFF);
    check(PIN_PU_EN, 16'h00F0);
    @(posedge REF_CLK);
    SIO_REGULATED <= 8'h00;
    $display("test bypass and regulated done");
  endtask : t_bypass_sio
  // Pin form sets pin 3 to strong drive with slow slew over port-form state
  task automatic t_pinform();
    port_wr(`IOPC_R_SLW, 8'h00);
    set_mode(3'h1, 8'h00);
    @(posedge REF_CLK);
    PIN_WR <= 1'b1;
    PIN_IDX <= 3'h3;
    PIN_WDATA <= 8'h2D;
    settle();
    check({PIN_OE, PIN_OUT & PIN_OE}, 16'h0808);
    check(PIN_SLOW, 16'h0008);
    port_wr(`IOPC_R_DR, 8'h00);
    settle();
    check({PIN_OE, PIN_OUT & PIN_OE}, 16'h0800);
    $display("test pin form done");
  endtask : t_pinform
  // Pin k follows aux enable k+8, so the upper half of the bus is used
  task automatic t_bidir();
    set_mode(3'h6, 8'hFF);
    for (int k = 0; k < 8; k++) port_wr(`IOPC_R_OESEL, {4'(k + 8), 1'b0, 3'(k)});
    port_wr(`IOPC_R_BIE, 8'hFF);
    AUX_OE <= 16'hAA00;
    settle();
    check({PIN_OE, PIN_IBUF_EN}, 16'hAAFF);
    @(posedge REF_CLK);
    AUX_OE <= 16'h5500;
    settle();
    check(PIN_OE, 16'h0055);
    port_wr(`IOPC_R_BIE, 8'h00);
    settle();
    $display("test bidirectional done");
  endtask : t_bidir
  task automatic t_ctl();
    port_wr(`IOPC_R_CTL, 8'h01);
    settle();
    check(LVTTL_SEL, 16'h0001);
    port_wr(4'hC, 8'h00);
    settle();
    check(LVTTL_SEL, 16'h0001);
    port_wr(`IOPC_R_CTL, 8'h00);
    settle();
    check(LVTTL_SEL, 16'h0000);
    $display("test threshold done");
  endtask : t_ctl
  // Pin 0 rising, pin 1 falling, pin 2 both, pin 3 none
  task automatic t_irq();
    set_mode(3'h1, 8'h00);
    ext_val <= 8'h00;
    ext_en <= 8'hFF;
    port_wr(`IOPC_R_RISE, 8'h05);
    port_wr(`IOPC_R_FALL, 8'h06);
    settle();
    repeat (3) @(posedge REF_CLK);
    ext_val <= 8'h0F;
    repeat (2) @(posedge REF_CLK);
    #1;
    check({IRQ_STATUS, 7'h00, IRQ}, 16'h0000);
    @(posedge REF_CLK);
    #1;
    check({IRQ_STATUS, 7'h00, IRQ}, 16'h0501);
    check(PIN_STATE, 16'h000F);
    repeat (5) @(posedge REF_CLK);
    #1;
    check(IRQ_STATUS, 16'h0005);
    @(posedge REF_CLK);
    STATUS_RD <= 1'b1;
    settle();
    check({IRQ_STATUS, 7'h00, IRQ}, 16'h0000);
    ext_val <= 8'h00;
    repeat (5) @(posedge REF_CLK);
    #1;
    check({IRQ_STATUS, 7'h00, IRQ}, 16'h0601);
    port_wr(`IOPC_R_INPD, 8'hFF);
    STATUS_RD <= 1'b1;
    settle();
    ext_val <= 8'h0F;
    repeat (6) @(posedge REF_CLK);
    #1;
    check({IRQ_STATUS, PIN_STATE}, 16'h0000);
    $display("test interrupts done");
  endtask : t_irq
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    RESET = 1'b1;
    {PORT_WR, PIN_WR, STATUS_RD} = 3'h0;
    {PORT_ADDR, PORT_WDATA, PIN_WDATA, PIN_IDX} = '0;
    NV_RST_DM = 3'h7;
    {BYP_DATA, SIO_REGULATED, ext_en, ext_val} = '0;
    AUX_OE = 16'h0000;
    t_reset();
    t_modes();
    t_bypass_sio();
    t_pinform();
    t_bidir();
    t_ctl();
    t_irq();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge REF_CLK);
    err_count++;
    final_report();
  end
endmodule : iopc_port_tb
`default_nettype wire
